// >>> rtl/supervisor_pkg.sv
// Constants shared by the supply supervisor core.
// Assumes comparator results arrive as synchronous levels on clk_i.
// Operation
// - Each rail output low while its rail is under threshold.
// - Margin input low forces every output high; the core leaves tol_ten_pct_o following tolerance select.
// - Tolerance select low picks 5 percent set, high picks 10 percent.
// - Reset variant: stuck kick input past timeout asserts reset, clears timer.
// - Reset variant: timer clears on reset and on any kick edge.
// - Reset variant: startup window of 54s awaits first kick edge.
// - Floating kick input disables the watchdog.
// - Separate variant: stuck kick asserts watchdog output; edges clear timer.
// - Separate variant: no startup window.
// - Manual reset low holds reset output low.
// - Reset stays low one full timeout after manual reset release.
// - Reset low on any undervoltage; release one timeout after all good.
// - Timeout-set strapped high selects internal timeout of at least 140ms.
// - Watchdog output low on undervoltage; released on recovery, kick, manual.
package supervisor_pkg;
   localparam int unsigned NUM_RAILS    = 6;
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned TB_DIV       = 40_000;
   localparam int unsigned TB_HZ        = CLK_HZ / TB_DIV;
   localparam int unsigned RST_TMO_MS   = 140;
   localparam int unsigned RST_TMO_TICKS = (RST_TMO_MS * TB_HZ + 999) / 1000;
   localparam int unsigned WD_TMO_MS    = 1600;
   localparam int unsigned WD_TMO_TICKS = (WD_TMO_MS * TB_HZ) / 1000;
   localparam int unsigned WD_START_S   = 54;
   localparam int unsigned WD_START_TICKS = WD_START_S * TB_HZ;
   localparam int unsigned CNT_W        = 20;
   localparam logic        VAR_RESET    = 1'b0;
   localparam logic        VAR_SEPARATE = 1'b1;
endpackage : supervisor_pkg

// >>> rtl/time_base.sv
// Time-base divider: one-cycle tick every DIV clocks.
// Assumes a single free-running clock.
`timescale 1ns/1ps
module time_base #(
   parameter int unsigned DIV = supervisor_pkg::TB_DIV
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   output logic      tick_o
);
   logic [19:0] cnt_r;
   logic [19:0] cnt_nxt;

   always_comb begin
      if (cnt_r == 20'(DIV - 1)) cnt_nxt = 20'h0;
      else cnt_nxt = cnt_r + 20'h1;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) cnt_r <= 20'h0;
      else cnt_r <= cnt_nxt;
   end

   assign tick_o = (cnt_r == 20'(DIV - 1));
endmodule : time_base

// >>> rtl/supply_supervisor_watchdog.sv
// Digital core of a six-rail supervisor with reset stretch and watchdog.
// Assumes comparators, reference and floating detector are analog,
// delivering synchronous levels; thresholds are applied outside.
`timescale 1ns/1ps
module supply_supervisor_watchdog #(
   parameter logic        VARIANT   = supervisor_pkg::VAR_RESET,
   parameter int unsigned TB_DIV    = supervisor_pkg::TB_DIV,
   parameter int unsigned RST_TICKS = supervisor_pkg::RST_TMO_TICKS,
   parameter int unsigned WD_TICKS  = supervisor_pkg::WD_TMO_TICKS,
   parameter int unsigned ST_TICKS  = supervisor_pkg::WD_START_TICKS,
   parameter int unsigned EXT_TICKS = supervisor_pkg::RST_TMO_TICKS
) (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic [5:0] rail_under_i,
   input  wire logic       margin_n_i,
   input  wire logic       tolerance_select_i,
   input  wire logic       manual_reset_n_i,
   input  wire logic       timeout_set_i,
   input  wire logic       wd_kick_in_i,
   input  wire logic       wd_kick_float_i,
   output logic            tol_ten_pct_o,
   output logic [5:0]      rail_good_n_o,
   output logic            reset_n_o,
   output logic            wd_expired_n_o
);
   localparam int W = supervisor_pkg::CNT_W;

   typedef enum logic [1:0] {WD_OFF, WD_START, WD_RUN} wd_state_t;

   function automatic logic reached(input logic [W-1:0] c,
                                    input int unsigned lim);
      reached = (c >= W'(lim));
   endfunction : reached

   // Advance a counter by one on a time-base tick
   function automatic logic [W-1:0] step(input logic [W-1:0] c,
                                         input logic         t);
      step = t ? c + W'(1) : c;
   endfunction : step

   logic tick;
   time_base #(.DIV(TB_DIV)) u_tb (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .tick_o (tick)
   );

   logic [5:0]   rail_n_r;
   logic [5:0]   rail_n_nxt;
   logic         rst_n_r;
   logic         rst_n_nxt;
   logic [W-1:0] rcnt_r;
   logic [W-1:0] rcnt_nxt;
   logic         wdo_n_r;
   logic         wdo_n_nxt;
   logic [W-1:0] wcnt_r;
   logic [W-1:0] wcnt_nxt;
   logic         kick_d_r;
   logic         kick_d_nxt;
   logic         wd_fire_r;
   logic         wd_fire_nxt;
   wd_state_t    wst_r;
   wd_state_t    wst_nxt;
   logic         tol_r;
   logic         tol_nxt;

   logic         any_under;
   logic         hold;
   logic         edge_seen;
   int unsigned  rst_lim;

   assign any_under = |rail_under_i;
   assign edge_seen = wd_kick_in_i ^ kick_d_r;
   // Capacitor timeout is analog; a parameter stands in for it
   assign rst_lim   = timeout_set_i ? RST_TICKS : EXT_TICKS;
   // A watchdog bite feeds the reset only in the reset variant
   assign hold      = any_under || !manual_reset_n_i
                      || (wd_fire_r && VARIANT == supervisor_pkg::VAR_RESET);

   // Per-rail outputs, one cycle behind the comparators
   always_comb begin
      rail_n_nxt = ~rail_under_i;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rail_n_r <= 6'h00;
      end else begin
         rail_n_r <= rail_n_nxt;
      end
   end

   // Reset stretch; counter restarts while any cause holds
   always_comb begin
      rst_n_nxt = rst_n_r;
      rcnt_nxt  = rcnt_r;
      if (hold) begin
         rst_n_nxt = 1'b0;
         rcnt_nxt  = '0;
      end else if (!rst_n_r) begin
         if (reached(rcnt_r, rst_lim)) rst_n_nxt = 1'b1;
         else rcnt_nxt = step(rcnt_r, tick);
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_n_r <= 1'b0;
         rcnt_r  <= '0;
      end else begin
         rst_n_r <= rst_n_nxt;
         rcnt_r  <= rcnt_nxt;
      end
   end

   // Kick edge detector; idles low so reset brings no false edge
   always_comb begin
      kick_d_nxt = wd_kick_in_i;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         kick_d_r <= 1'b0;
      end else begin
         kick_d_r <= kick_d_nxt;
      end
   end

   // Watchdog; in the reset variant counts only once reset output has released
   always_comb begin
      wst_nxt     = wst_r;
      wcnt_nxt    = wcnt_r;
      wd_fire_nxt = 1'b0;
      if (wd_kick_float_i) begin
         wst_nxt  = WD_OFF;
         wcnt_nxt = '0;
      end else case (wst_r)
         WD_OFF: begin
            wcnt_nxt = '0;
            if (VARIANT == supervisor_pkg::VAR_RESET) wst_nxt = WD_START;
            else wst_nxt = WD_RUN;
         end
         WD_START: begin
            if (!rst_n_r) wcnt_nxt = '0;
            else if (edge_seen) begin
               wcnt_nxt = '0;
               wst_nxt  = WD_RUN;
            end else if (reached(wcnt_r, ST_TICKS)) begin
               wd_fire_nxt = 1'b1;
               wcnt_nxt    = '0;
            end else wcnt_nxt = step(wcnt_r, tick);
         end
         WD_RUN: begin
            if (VARIANT == supervisor_pkg::VAR_RESET && !rst_n_r) begin
               wcnt_nxt = '0;
               wst_nxt  = WD_START;
            end else if (edge_seen) wcnt_nxt = '0;
            else if (reached(wcnt_r, WD_TICKS)) begin
               wd_fire_nxt = 1'b1;
               wcnt_nxt    = '0;
            end else wcnt_nxt = step(wcnt_r, tick);
         end
         default: wst_nxt = WD_OFF;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wst_r     <= WD_OFF;
         wcnt_r    <= '0;
         wd_fire_r <= 1'b0;
      end else begin
         wst_r     <= wst_nxt;
         wcnt_r    <= wcnt_nxt;
         wd_fire_r <= wd_fire_nxt;
      end
   end

   // Separate output follows rails directly, no stretch
   always_comb begin
      wdo_n_nxt = wdo_n_r;
      if (any_under) wdo_n_nxt = 1'b0;
      else if (edge_seen || !manual_reset_n_i) wdo_n_nxt = 1'b1;
      else if (wd_fire_r) wdo_n_nxt = 1'b0;
      // Rails were under last cycle: release at once
      else if (!wdo_n_r && rail_n_r != 6'h3f) wdo_n_nxt = 1'b1;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wdo_n_r <= 1'b0;
      end else begin
         wdo_n_r <= wdo_n_nxt;
      end
   end

   // Threshold set choice handed to the analog comparators
   always_comb begin
      tol_nxt = tolerance_select_i;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tol_r <= 1'b0;
      end else begin
         tol_r <= tol_nxt;
      end
   end

   // Margin overrides every output except tol_ten_pct_o
   assign tol_ten_pct_o  = tol_r;
   assign rail_good_n_o  = margin_n_i ? rail_n_r : 6'h3f;
   assign reset_n_o      = margin_n_i ? rst_n_r : 1'b1;
   assign wd_expired_n_o = (!margin_n_i
                           || VARIANT == supervisor_pkg::VAR_RESET)
                           ? 1'b1 : wdo_n_r;
endmodule : supply_supervisor_watchdog

// >>> tb/supervisor_chk.sv
// Checker on the supervisor core ports.
// Assumes the bench keeps inputs steady during reset.
`timescale 1ns/1ps
module supervisor_chk #(
   parameter logic VARIANT = 1'b0
) (
   input wire logic       clk_i,
   input wire logic       rstn_i,
   input wire logic [5:0] rail_under_i,
   input wire logic       margin_n_i,
   input wire logic       tolerance_select_i,
   input wire logic       manual_reset_n_i,
   input wire logic       timeout_set_i,
   input wire logic       tol_ten_pct_o,
   input wire logic [5:0] rail_good_n_o,
   input wire logic       reset_n_o,
   input wire logic       wd_expired_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_mr_up;
      margin_n_i && timeout_set_i && $rose(manual_reset_n_i);
   endsequence
   sequence s_low; (!reset_n_o || !margin_n_i)[*7]; endsequence
   a_rail_follow: assert property (margin_n_i && $past(rstn_i)
      |-> rail_good_n_o == ~$past(rail_under_i)) else $error("rail out");
   a_margin_high: assert property (!margin_n_i |-> rail_good_n_o == 6'h3f
      && reset_n_o && wd_expired_n_o) else $error("margin");
   a_tol_follow: assert property ($past(rstn_i)
      |-> tol_ten_pct_o == $past(tolerance_select_i)) else $error("tol");
   a_rail_reset: assert property (margin_n_i
      && $past(rail_under_i) != 6'h00 |-> !reset_n_o) else $error("rail rst");
   a_manual_low: assert property (margin_n_i
      && !$past(manual_reset_n_i) |-> !reset_n_o) else $error("manual");
   a_mr_stretch: assert property (s_mr_up |-> s_low)
      else $error("stretch");
   a_release_cause: assert property ($rose(reset_n_o) && $past(margin_n_i)
      |-> $past(rail_under_i, 4) == 6'h00 && $past(manual_reset_n_i, 4))
      else $error("early release");
   a_wd_tied: assert property (VARIANT == 1'b0 |-> wd_expired_n_o)
      else $error("wd out");
endmodule : supervisor_chk
bind supply_supervisor_watchdog supervisor_chk #(.VARIANT(VARIANT)) u_chk (.*);

// >>> tb/host_model.sv
// Host model: toggles the kick line while reset is released.
// Assumes the bench enables the kick and may leave the line floating; the gap is fixed at 7 clocks.
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       kick_en_i,
   input  wire logic       float_i,
   output logic            kick_o,
   output logic            float_o
);
   logic [3:0] cnt_r = 4'h0;
   initial kick_o = 1'b0;
   assign float_o = float_i;
   always @(posedge clk_i) begin
      #1;
      // Floating line held still; only the detector may stop the timer
      if (float_i) cnt_r = 4'h0;
      else if (!reset_n_i || !kick_en_i) cnt_r = 4'h0;
      else if (cnt_r == 4'h6) begin
         cnt_r = 4'h0;
         kick_o = ~kick_o;
      end else cnt_r = cnt_r + 4'h1;
   end
endmodule : host_model

// >>> tb/supply_supervisor_watchdog_tb_top.sv
// Bench for the supervisor core, reset variant, shortened counts.
// Assumes host_model drives the kick and the checker is bound.
`timescale 1ns/1ps
module supply_supervisor_watchdog_tb_top;
   logic       clk_i = 1'b0, rstn_i = 1'b0, mrn = 1'b1, mgn = 1'b1;
   logic       tolerance_select = 1'b0, ken = 1'b1, flt = 1'b0, chk = 1'b0, tset = 1'b1;
   logic [5:0] rail = 6'h00, good_n;
   logic       kick, kflt, tol_o, rst_n, wd_n;
   logic [8:0] q[$];
   int         n_mismatch = 0, tests_run = 0, i;
   always #12.5 clk_i = ~clk_i;
   supply_supervisor_watchdog #(.TB_DIV(4), .RST_TICKS(3), .WD_TICKS(5),
      .ST_TICKS(8), .EXT_TICKS(2)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
      .rail_under_i(rail), .margin_n_i(mgn), .tolerance_select_i(tolerance_select),
      .manual_reset_n_i(mrn), .timeout_set_i(tset), .wd_kick_in_i(kick),
      .wd_kick_float_i(kflt), .tol_ten_pct_o(tol_o),
      .rail_good_n_o(good_n), .reset_n_o(rst_n), .wd_expired_n_o(wd_n));
   host_model u_host (.clk_i(clk_i), .reset_n_i(rst_n), .kick_en_i(ken),
      .float_i(flt), .kick_o(kick), .float_o(kflt));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc
   task automatic exp_out(input logic r, input logic [5:0] g);
      // Watchdog output stays high in the reset variant
      q.push_back({1'b1, tolerance_select, r, g});
      chk = 1'b1;
      cyc(1);
   endtask : exp_out
   task automatic wait_rst(input logic v);
      for (int k = 0; k < 80 && rst_n !== v; k++) cyc(1);
   endtask : wait_rst
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL outputs exp %h seen %h", exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   always @(negedge clk_i) if (chk) begin
      check({wd_n, tol_o, rst_n, good_n}, q.pop_front());
      chk <= 1'b0;
   end
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      void'($urandom(63648));
      cyc(6);
      rstn_i = 1'b1;
      cyc(16);
      exp_out(1'b1, 6'h3f);
      for (i = 0; i < 6; i++) begin
         rail = 6'($urandom) | (6'h01 << i);
         tolerance_select = 1'($urandom);
         tset = 1'($urandom);
         cyc(2);
         exp_out(1'b0, ~rail);
         rail = 6'h00;
         cyc(2);
         exp_out(1'b0, 6'h3f);
         cyc(6);
         exp_out(!tset, 6'h3f);
         cyc(9);
         exp_out(1'b1, 6'h3f);
      end
      tset = 1'b1;
      rail = 6'h2a;
      mgn = 1'b0;
      cyc(1);
      exp_out(1'b1, 6'h3f);
      rail = 6'h00;
      mgn = 1'b1;
      mrn = 1'b0;
      cyc(3);
      exp_out(1'b0, 6'h3f);
      mrn = 1'b1;
      cyc(5);
      exp_out(1'b0, 6'h3f);
      cyc(60);
      exp_out(1'b1, 6'h3f);
      ken = 1'b0;
      wait_rst(1'b0);
      exp_out(1'b0, 6'h3f);
      wait_rst(1'b1);
      cyc(25);
      exp_out(1'b1, 6'h3f);
      wait_rst(1'b0);
      exp_out(1'b0, 6'h3f);
      flt = 1'b1;
      wait_rst(1'b1);
      cyc(60);
      exp_out(1'b1, 6'h3f);
      end_of_test();
   end
endmodule : supply_supervisor_watchdog_tb_top
